// ===== rtl/uel_pkg.sv
package uel_pkg;

    // Register offsets on the configuration port
    localparam logic [7:0] DOWNSTREAM_RX_EQ_SELECT_OFS = 8'h20;
    localparam logic [7:0] UPSTREAM_RX_EQ_SELECT_OFS = 8'h21;
    localparam logic [7:0] LINK_MISC_CONTROL_OFS = 8'h22;

    // Values after reset
    localparam logic [7:0] DOWNSTREAM_RX_EQ_SELECT_RST = 8'h00;
    localparam logic [7:0] UPSTREAM_RX_EQ_SELECT_RST = 8'h00;
    localparam logic [7:0] LINK_MISC_CONTROL_RST = 8'h44;

    // Field positions
    localparam int SECOND_EQ_LSB = 4;
    localparam int FIRST_EQ_LSB = 0;
    localparam int HOST_EQ_LSB = 0;
    localparam int TERM_OFF_BIT = 7;
    localparam int LFPS_EQUALIZATION_APPLY_BIT = 6;
    localparam int DEBOUNCE_BIT = 5;
    localparam int DETECT_INHIBIT_BIT = 4;
    localparam int PERIOD_LSB = 2;
    localparam int WARM_SKIP_BIT = 1;
    localparam int COMPLIANCE_DIS_BIT = 0;

    // Times and derived cycle counts at 200 MHz
    localparam int CLK_PERIOD_PS = 5000;
    localparam int DEBOUNCE_US = 200;
    localparam int DETECT_6_MS = 6;
    localparam int DETECT_36_MS = 36;
    localparam int DETECT_84_MS = 84;
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DETECT_6_CYCLES = DETECT_6_MS * 200000;
    localparam int DETECT_36_CYCLES = DETECT_36_MS * 200000;
    localparam int DETECT_84_CYCLES = DETECT_84_MS * 200000;

    localparam logic [1:0] PERIOD_RESERVED = 2'h0;
    localparam int SYNC_STAGES = 3;

    typedef struct packed {
        logic [3:0] secondEq;
        logic [3:0] firstEq;
        logic [3:0] hostEq;
    } uel_eq_type;

    typedef struct packed {
        logic termOff;
        logic detectInhibit;
        logic complianceDisable;
        logic warmDetectSkip;
        logic detectTick;
        logic lfpsExit;
    } uel_link_type;

endpackage : uel_pkg

// ===== rtl/uel_pin_sync.sv
module uel_pin_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Pins and synchronised result
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut
);
    import uel_pkg::*;

    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_r <= '0;
            stage2_r <= '0;
            stage3_r <= '0;
            pinOut <= '0;
        end else begin
            stage1_r <= pinIn;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            // A change counts once the two late stages agree
            if (stage2_r == stage3_r) begin
                pinOut <= stage3_r;
            end
        end
    end

endmodule : uel_pin_sync

// ===== rtl/uel_interval_timer.sv
module uel_interval_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control
    input wire logic [1:0] periodCode,
    input wire logic runEnable,
    // One-cycle tick when the interval elapses
    output logic tick
);
    import uel_pkg::*;

    logic [24:0] count_r;
    logic [24:0] limit;

    always_comb begin
        unique case (periodCode)
            2'h1: limit = 25'(DETECT_6_CYCLES - 1);
            2'h2: limit = 25'(DETECT_36_CYCLES - 1);
            2'h3: limit = 25'(DETECT_84_CYCLES - 1);
            // Reserved code runs at the shortest interval
            default: limit = 25'(DETECT_6_CYCLES - 1);
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
            tick <= 1'b0;
        end else if (!runEnable) begin
            count_r <= '0;
            tick <= 1'b0;
        end else if (count_r >= limit) begin
            count_r <= '0;
            tick <= 1'b1;
        end else begin
            count_r <= count_r + 25'h000_0001;
            tick <= 1'b0;
        end
    end

endmodule : uel_interval_timer

// ===== rtl/uel_rx_eq_link_regs.sv
// Summary of operation
// - Adaptive off: bits 7-4 of downstream register drive second receiver equalization.
// - Adaptive off: bits 3-0 of downstream register drive first receiver equalization.
// - Override clear: downstream fields read back the sampled downstream strap pins.
// - Override set: software writes downstream fields and they are applied.
// - Adaptive on, even algorithm, short channel: downstream fields are the settings.
// - Upstream bits 3-0 set host-facing equalization; bits 7-4 read zero.
// - Override clear: upstream field reads back the sampled upstream strap pins.
// - Override set: software writes to upstream field change host-facing equalization.
// - Link bit 7: zero keeps termination at detection start, one removes it.
// - Link bit 6: one applies programmed equalization on LFPS, zero forces zero.
// - Link bit 5 set: LFPS debounced 200us before low-power exit; clear: none.
// - Link bit 4 set suppresses receiver detection in U2/U3; clear allows it.
// - Link bits 3-2 select detect interval 6, 36 or 84 ms; reset code 1.
// - Link bit 1 set: skip detection after warm reset when polling seen.
// - Link bit 0 set disables compliance mode; clear lets the link decide.
// - Separate adaptive enable bit gates adaptive operation for downstream receivers.
// - Adaptive, even algorithm, long channel: long-channel fields supply the settings.
module uel_rx_eq_link_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Configuration port
    input wire logic cfgWrite,
    input wire logic cfgRead,
    input wire logic [7:0] cfgAddr,
    input wire logic [7:0] cfgWdata,
    output logic [7:0] cfgRdata,
    output logic cfgRvalid,
    // Neighbouring controls and adaptive results
    input wire logic software_eq_takeover,
    input wire logic adaptive_eq_enable,
    input wire logic [1:0] adaptive_eq_algorithm,
    input wire logic longChannelDetected,
    input wire logic [3:0] first_port_long_channel_eq,
    input wire logic [3:0] second_port_long_channel_eq,
    // Strap pins
    input wire logic [1:0] downstream_eq_strap_pins,
    input wire logic [1:0] upstream_eq_strap_pins,
    // Link state from the link state machine
    input wire logic lfpsReceiving,
    input wire logic lfpsPresent,
    input wire logic inLowPower,
    input wire logic warmResetActive,
    input wire logic warmResetPollingSeen,
    // Equalization applied to receivers
    output uel_pkg::uel_eq_type appliedEq,
    // Link management controls
    output uel_pkg::uel_link_type linkCtl
);
    import uel_pkg::*;

    logic [3:0] second_port_eq_level_r;
    logic [3:0] first_port_eq_level_r;
    logic [3:0] host_side_eq_level_r;
    logic [7:0] linkMisc_r;
    logic [1:0] dsStrap;
    logic [1:0] usStrap;
    logic strapLoaded_r;
    logic [3:0] secondSel;
    logic [3:0] firstSel;
    logic [3:0] hostSel;
    logic [15:0] debounceCnt_r;
    logic debounced_r;
    logic detectTick;
    logic warmSkip_r;
    logic timerRun;
    logic adaptiveEven;

    uel_pin_sync #(.WIDTH(4)) strapSync (
        .clk(clk),
        .reset_n(reset_n),
        .pinIn({downstream_eq_strap_pins, upstream_eq_strap_pins}),
        .pinOut({dsStrap, usStrap})
    );

    // Widen two-pin strap to a four-bit level
    function automatic logic [3:0] strapLevel(input logic [1:0] pins);
        strapLevel = {2'h0, pins};
    endfunction : strapLevel

    function automatic logic isWrite(input logic we, input logic [7:0] a, input logic [7:0] ofs);
        isWrite = we && (a == ofs);
    endfunction : isWrite

    // Downstream fields: strap when not overridden, software otherwise
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            second_port_eq_level_r <= DOWNSTREAM_RX_EQ_SELECT_RST[7:4];
            first_port_eq_level_r <= DOWNSTREAM_RX_EQ_SELECT_RST[3:0];
        end else if (!software_eq_takeover) begin
            second_port_eq_level_r <= strapLevel(dsStrap);
            first_port_eq_level_r <= strapLevel(dsStrap);
        end else if (isWrite(cfgWrite, cfgAddr, DOWNSTREAM_RX_EQ_SELECT_OFS)) begin
            second_port_eq_level_r <= cfgWdata[SECOND_EQ_LSB +: 4];
            first_port_eq_level_r <= cfgWdata[FIRST_EQ_LSB +: 4];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            host_side_eq_level_r <= UPSTREAM_RX_EQ_SELECT_RST[3:0];
        end else if (!software_eq_takeover) begin
            host_side_eq_level_r <= strapLevel(usStrap);
        end else if (isWrite(cfgWrite, cfgAddr, UPSTREAM_RX_EQ_SELECT_OFS)) begin
            host_side_eq_level_r <= cfgWdata[HOST_EQ_LSB +: 4];
        end
    end

    // Set on the first clock after reset, before the strap has passed the synchroniser
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strapLoaded_r <= 1'b0;
        end else begin
            strapLoaded_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            linkMisc_r <= LINK_MISC_CONTROL_RST;
        end else if (isWrite(cfgWrite, cfgAddr, LINK_MISC_CONTROL_OFS)) begin
            linkMisc_r <= cfgWdata;
        end
    end

    // Read path
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfgRdata <= 8'h00;
            cfgRvalid <= 1'b0;
        end else begin
            cfgRvalid <= cfgRead;
            if (cfgRead) begin
                unique case (cfgAddr)
                    DOWNSTREAM_RX_EQ_SELECT_OFS:
                        cfgRdata <= {second_port_eq_level_r, first_port_eq_level_r};
                    UPSTREAM_RX_EQ_SELECT_OFS: cfgRdata <= {4'h0, host_side_eq_level_r};
                    LINK_MISC_CONTROL_OFS: cfgRdata <= linkMisc_r;
                    default: cfgRdata <= 8'h00;
                endcase
            end
        end
    end

    // Equalization selection
    assign adaptiveEven = adaptive_eq_enable && !adaptive_eq_algorithm[0];

    always_comb begin
        secondSel = second_port_eq_level_r;
        firstSel = first_port_eq_level_r;
        if (adaptiveEven && longChannelDetected) begin
            secondSel = second_port_long_channel_eq;
            firstSel = first_port_long_channel_eq;
        end
        // Short channel keeps the register fields
        hostSel = host_side_eq_level_r;
        if (lfpsReceiving && !linkMisc_r[LFPS_EQUALIZATION_APPLY_BIT]) begin
            secondSel = 4'h0;
            firstSel = 4'h0;
            hostSel = 4'h0;
        end
    end

    // Adaptive odd codes belong to the full-adaption engine outside; fields still drive it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            appliedEq <= '0;
        end else begin
            appliedEq.secondEq <= secondSel;
            appliedEq.firstEq <= firstSel;
            appliedEq.hostEq <= hostSel;
        end
    end

    // LFPS debounce before low-power exit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            debounceCnt_r <= '0;
            debounced_r <= 1'b0;
        end else if (!lfpsPresent || !inLowPower) begin
            debounceCnt_r <= '0;
            debounced_r <= 1'b0;
        end else if (debounceCnt_r >= 16'(DEBOUNCE_CYCLES - 1)) begin
            debounced_r <= 1'b1;
        end else begin
            debounceCnt_r <= debounceCnt_r + 16'h0001;
        end
    end

    // Polling during warm reset is remembered until a detection tick once reset and polling have both ended
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            warmSkip_r <= 1'b0;
        end else if (warmResetActive && warmResetPollingSeen) begin
            warmSkip_r <= 1'b1;
        end else if (!warmResetActive && !warmResetPollingSeen) begin
            warmSkip_r <= warmSkip_r && !detectTick;
        end
    end

    assign timerRun = !(inLowPower && linkMisc_r[DETECT_INHIBIT_BIT]);

    uel_interval_timer detectTimer (
        .clk(clk),
        .reset_n(reset_n),
        .periodCode(linkMisc_r[PERIOD_LSB +: 2]),
        .runEnable(timerRun),
        .tick(detectTick)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            linkCtl <= '0;
        end else begin
            linkCtl.termOff <= linkMisc_r[TERM_OFF_BIT];
            linkCtl.detectInhibit <= inLowPower && linkMisc_r[DETECT_INHIBIT_BIT];
            linkCtl.complianceDisable <= linkMisc_r[COMPLIANCE_DIS_BIT];
            linkCtl.warmDetectSkip <= linkMisc_r[WARM_SKIP_BIT] && warmSkip_r;
            linkCtl.detectTick <= detectTick && timerRun;
            linkCtl.lfpsExit <= inLowPower && lfpsPresent
                && (linkMisc_r[DEBOUNCE_BIT] ? debounced_r : 1'b1);
        end
    end

    chk_lfps_zero_eq: assert property (@(posedge clk) disable iff (!reset_n)
        (lfpsReceiving && !linkMisc_r[LFPS_EQUALIZATION_APPLY_BIT]) |=> appliedEq == '0)
        else $error("LFPS equalization not forced to zero");

    chk_lfps_keeps_eq: assert property (@(posedge clk) disable iff (!reset_n)
        (lfpsReceiving && linkMisc_r[LFPS_EQUALIZATION_APPLY_BIT])
        |=> appliedEq.hostEq == $past(host_side_eq_level_r))
        else $error("LFPS equalization not taken from field");

    chk_upper_bits_zero: assert property (@(posedge clk) disable iff (!reset_n)
        (cfgRead && cfgAddr == UPSTREAM_RX_EQ_SELECT_OFS) |=> cfgRdata[7:4] == 4'h0)
        else $error("Upstream reserved bits not zero");

    chk_strap_tracks: assert property (@(posedge clk) disable iff (!reset_n)
        (!software_eq_takeover && $stable(dsStrap))
        |=> first_port_eq_level_r == strapLevel($past(dsStrap)))
        else $error("Downstream field not following strap");

    chk_host_strap: assert property (@(posedge clk) disable iff (!reset_n)
        (!software_eq_takeover) |=> host_side_eq_level_r == strapLevel($past(usStrap)))
        else $error("Upstream field not following strap");

    chk_ds_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (software_eq_takeover && !isWrite(cfgWrite, cfgAddr, DOWNSTREAM_RX_EQ_SELECT_OFS))
        |=> $stable({second_port_eq_level_r, first_port_eq_level_r}))
        else $error("Downstream field moved under override");

    chk_us_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (software_eq_takeover && !isWrite(cfgWrite, cfgAddr, UPSTREAM_RX_EQ_SELECT_OFS))
        |=> $stable(host_side_eq_level_r))
        else $error("Upstream field moved under override");

    chk_sw_write_ds: assert property (@(posedge clk) disable iff (!reset_n)
        (software_eq_takeover && cfgWrite && cfgAddr == DOWNSTREAM_RX_EQ_SELECT_OFS)
        |=> {second_port_eq_level_r, first_port_eq_level_r} == $past(cfgWdata))
        else $error("Downstream write lost");

    chk_sw_write_us: assert property (@(posedge clk) disable iff (!reset_n)
        (software_eq_takeover && cfgWrite && cfgAddr == UPSTREAM_RX_EQ_SELECT_OFS)
        ##1 (software_eq_takeover && !lfpsReceiving)
        |=> appliedEq.hostEq == $past(cfgWdata[3:0], 2))
        else $error("Upstream write not applied");

    chk_fixed_second: assert property (@(posedge clk) disable iff (!reset_n)
        (!adaptive_eq_enable && !lfpsReceiving)
        |=> appliedEq.secondEq == $past(second_port_eq_level_r))
        else $error("Second receiver level not applied");

    chk_fixed_first: assert property (@(posedge clk) disable iff (!reset_n)
        (!adaptive_eq_enable && !lfpsReceiving)
        |=> appliedEq.firstEq == $past(first_port_eq_level_r))
        else $error("First receiver level not applied");

    chk_short_channel: assert property (@(posedge clk) disable iff (!reset_n)
        (adaptiveEven && !longChannelDetected && !lfpsReceiving)
        |=> {appliedEq.secondEq, appliedEq.firstEq}
            == $past({second_port_eq_level_r, first_port_eq_level_r}))
        else $error("Short channel setting not used");

    chk_long_channel: assert property (@(posedge clk) disable iff (!reset_n)
        (adaptiveEven && longChannelDetected && !lfpsReceiving)
        |=> appliedEq.firstEq == $past(first_port_long_channel_eq))
        else $error("Long channel setting not used");

    chk_long_second: assert property (@(posedge clk) disable iff (!reset_n)
        (adaptiveEven && longChannelDetected && !lfpsReceiving)
        |=> appliedEq.secondEq == $past(second_port_long_channel_eq))
        else $error("Second long channel setting not used");

    chk_link_write: assert property (@(posedge clk) disable iff (!reset_n)
        (cfgWrite && cfgAddr == LINK_MISC_CONTROL_OFS) |=> linkMisc_r == $past(cfgWdata))
        else $error("Link control write lost");

    chk_read_valid: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> cfgRvalid == $past(cfgRead))
        else $error("Read valid not a one-cycle answer");

    chk_rdata_hold: assert property (@(posedge clk) disable iff (!reset_n)
        !cfgRead |=> $stable(cfgRdata))
        else $error("Read data moved without a read");

    chk_unmapped_read: assert property (@(posedge clk) disable iff (!reset_n)
        (cfgRead && cfgAddr != DOWNSTREAM_RX_EQ_SELECT_OFS
            && cfgAddr != UPSTREAM_RX_EQ_SELECT_OFS && cfgAddr != LINK_MISC_CONTROL_OFS)
        |=> cfgRdata == 8'h00)
        else $error("Unmapped read not zero");

    chk_no_debounce: assert property (@(posedge clk) disable iff (!reset_n)
        (!linkMisc_r[DEBOUNCE_BIT] && inLowPower && lfpsPresent) |=> linkCtl.lfpsExit)
        else $error("Undebounced exit missing");

    chk_debounce_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (linkMisc_r[DEBOUNCE_BIT] && $rose(lfpsPresent)) |=> !linkCtl.lfpsExit)
        else $error("Exit before debounce");

    chk_debounce_done: assert property (@(posedge clk) disable iff (!reset_n)
        (linkMisc_r[DEBOUNCE_BIT] && inLowPower && lfpsPresent && debounced_r)
        |=> linkCtl.lfpsExit)
        else $error("Debounced exit missing");

    chk_inhibit_tick: assert property (@(posedge clk) disable iff (!reset_n)
        (inLowPower && linkMisc_r[DETECT_INHIBIT_BIT]) |=> !linkCtl.detectTick)
        else $error("Detection ran while inhibited");

    chk_inhibit_level: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> linkCtl.detectInhibit == $past(inLowPower && linkMisc_r[DETECT_INHIBIT_BIT]))
        else $error("Detection inhibit level mismatch");

    chk_warm_skip_off: assert property (@(posedge clk) disable iff (!reset_n)
        !linkMisc_r[WARM_SKIP_BIT] |=> !linkCtl.warmDetectSkip)
        else $error("Warm reset detect skipped while not enabled");

    chk_warm_skip_set: assert property (@(posedge clk) disable iff (!reset_n)
        (linkMisc_r[WARM_SKIP_BIT] && warmResetActive && warmResetPollingSeen)
        ##1 linkMisc_r[WARM_SKIP_BIT] |=> linkCtl.warmDetectSkip)
        else $error("Warm reset detect skip missing");

    chk_compliance: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> linkCtl.complianceDisable == $past(linkMisc_r[COMPLIANCE_DIS_BIT]))
        else $error("Compliance control mismatch");

    chk_term_start: assert property (@(posedge clk) disable iff (!reset_n)
        strapLoaded_r |=> linkCtl.termOff == $past(linkMisc_r[TERM_OFF_BIT]))
        else $error("Termination control mismatch");

endmodule : uel_rx_eq_link_regs

// ===== tb/uel_rx_eq_link_regs_tb.sv
module uel_rx_eq_link_regs_tb import uel_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cfgWrite = 1'b0;
    logic cfgRead = 1'b0;
    logic [7:0] cfgAddr = 8'h00;
    logic [7:0] cfgWdata = 8'h00;
    logic [7:0] cfgRdata;
    logic cfgRvalid;
    logic takeover = 1'b0;
    logic aeqEnable = 1'b0;
    logic [1:0] aeqAlgorithm = 2'b00;
    logic longChannel = 1'b0;
    logic [3:0] firstLongEq = 4'hC;
    logic [3:0] secondLongEq = 4'h3;
    logic [1:0] downStrap = 2'b00;
    logic [1:0] upStrap = 2'b00;
    logic lfpsReceiving = 1'b0;
    logic lfpsPresent = 1'b0;
    logic inLowPower = 1'b0;
    logic warmResetActive = 1'b0;
    logic warmResetPollingSeen = 1'b0;
    uel_eq_type appliedEq;
    uel_link_type linkCtl;
    int nErrors = 0;
    int checks = 0;
    int cycles = 0;

    always #2.5 clk = ~clk;

    uel_rx_eq_link_regs DUT (
        .clk(clk), .reset_n(reset_n),
        .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgWdata(cfgWdata),
        .cfgRdata(cfgRdata), .cfgRvalid(cfgRvalid),
        .software_eq_takeover(takeover), .adaptive_eq_enable(aeqEnable),
        .adaptive_eq_algorithm(aeqAlgorithm), .longChannelDetected(longChannel),
        .first_port_long_channel_eq(firstLongEq), .second_port_long_channel_eq(secondLongEq),
        .downstream_eq_strap_pins(downStrap), .upstream_eq_strap_pins(upStrap),
        .lfpsReceiving(lfpsReceiving), .lfpsPresent(lfpsPresent), .inLowPower(inLowPower),
        .warmResetActive(warmResetActive), .warmResetPollingSeen(warmResetPollingSeen),
        .appliedEq(appliedEq), .linkCtl(linkCtl)
    );

    task automatic tally_and_finish();
        if (nErrors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    // Longest run is the debounce wait, well below this ceiling
    always @(posedge clk) begin
        cycles++;
        if (cycles == 70000) begin
            nErrors++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            nErrors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask : settle

    task automatic regWrite(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        cfgAddr = addr;
        cfgWdata = data;
        cfgWrite = 1'b1;
        @(negedge clk);
        cfgWrite = 1'b0;
    endtask : regWrite

    // Data counts only if the valid pulse shows within a few cycles
    task automatic expectRead(input logic [7:0] addr, input logic [7:0] exp);
        int n;
        logic [7:0] data;
        @(negedge clk);
        cfgAddr = addr;
        cfgRead = 1'b1;
        @(negedge clk);
        cfgRead = 1'b0;
        n = 0;
        while (cfgRvalid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        data = (cfgRvalid === 1'b1) ? cfgRdata : 8'hxx;
        check({8'h00, data}, {8'h00, exp});
        // Valid stands for one cycle only
        @(negedge clk);
        check({15'h0, cfgRvalid}, 16'h0000);
    endtask : expectRead

    task automatic checkEq(input logic [11:0] exp);
        settle(4);
        check({4'h0, appliedEq}, {4'h0, exp});
    endtask : checkEq

    task automatic test_reset_values();
        expectRead(LINK_MISC_CONTROL_OFS, 8'h44);
        expectRead(DOWNSTREAM_RX_EQ_SELECT_OFS, 8'h00);
        expectRead(UPSTREAM_RX_EQ_SELECT_OFS, 8'h00);
        expectRead(8'h2F, 8'h00);
    endtask : test_reset_values

    task automatic test_strap_follow();
        downStrap = 2'b10;
        upStrap = 2'b11;
        settle(10);
        regWrite(DOWNSTREAM_RX_EQ_SELECT_OFS, 8'hFF);
        regWrite(UPSTREAM_RX_EQ_SELECT_OFS, 8'hFF);
        expectRead(DOWNSTREAM_RX_EQ_SELECT_OFS, 8'h22);
        expectRead(UPSTREAM_RX_EQ_SELECT_OFS, 8'h03);
        checkEq(12'h223);
        downStrap = 2'b01;
        upStrap = 2'b00;
        settle(10);
        expectRead(DOWNSTREAM_RX_EQ_SELECT_OFS, 8'h11);
        expectRead(UPSTREAM_RX_EQ_SELECT_OFS, 8'h00);
    endtask : test_strap_follow

    task automatic test_override();
        takeover = 1'b1;
        settle(2);
        regWrite(DOWNSTREAM_RX_EQ_SELECT_OFS, 8'hA5);
        regWrite(UPSTREAM_RX_EQ_SELECT_OFS, 8'hF9);
        expectRead(DOWNSTREAM_RX_EQ_SELECT_OFS, 8'hA5);
        expectRead(UPSTREAM_RX_EQ_SELECT_OFS, 8'h09);
        checkEq(12'hA59);
        // Strap moves must no longer reach the fields
        downStrap = 2'b11;
        upStrap = 2'b11;
        settle(10);
        expectRead(DOWNSTREAM_RX_EQ_SELECT_OFS, 8'hA5);
        checkEq(12'hA59);
    endtask : test_override

    task automatic test_adaptive();
        logic [1:0] evenCodes [2] = '{2'b00, 2'b10};
        aeqEnable = 1'b1;
        foreach (evenCodes[i]) begin
            aeqAlgorithm = evenCodes[i];
            longChannel = 1'b0;
            checkEq(12'hA59);
            longChannel = 1'b1;
            checkEq(12'h3C9);
        end
        // Odd codes leave the long-channel fields unused
        aeqAlgorithm = 2'b01;
        checkEq(12'hA59);
        aeqEnable = 1'b0;
        checkEq(12'hA59);
        longChannel = 1'b0;
    endtask : test_adaptive

    task automatic test_lfps_equalization_apply();
        lfpsReceiving = 1'b1;
        checkEq(12'hA59);
        regWrite(LINK_MISC_CONTROL_OFS, 8'h04);
        checkEq(12'h000);
        lfpsReceiving = 1'b0;
        checkEq(12'hA59);
    endtask : test_lfps_equalization_apply

    task automatic test_link_bits();
        warmResetActive = 1'b1;
        warmResetPollingSeen = 1'b1;
        inLowPower = 1'b1;
        regWrite(LINK_MISC_CONTROL_OFS, 8'h95);
        settle(3);
        check({13'h0, linkCtl.termOff, linkCtl.detectInhibit, linkCtl.complianceDisable},
            16'h0007);
        check({15'h0, linkCtl.warmDetectSkip}, 16'h0000);
        check({15'h0, linkCtl.detectTick}, 16'h0000);
        regWrite(LINK_MISC_CONTROL_OFS, 8'h0E);
        expectRead(LINK_MISC_CONTROL_OFS, 8'h0E);
        settle(3);
        check({13'h0, linkCtl.termOff, linkCtl.detectInhibit, linkCtl.complianceDisable},
            16'h0000);
        check({15'h0, linkCtl.warmDetectSkip}, 16'h0001);
        warmResetActive = 1'b0;
        warmResetPollingSeen = 1'b0;
        inLowPower = 1'b0;
    endtask : test_link_bits

    task automatic test_debounce();
        regWrite(LINK_MISC_CONTROL_OFS, 8'h44);
        inLowPower = 1'b1;
        lfpsPresent = 1'b1;
        settle(3);
        check({15'h0, linkCtl.lfpsExit}, 16'h0001);
        lfpsPresent = 1'b0;
        settle(3);
        regWrite(LINK_MISC_CONTROL_OFS, 8'h64);
        lfpsPresent = 1'b1;
        settle(DEBOUNCE_CYCLES - 20);
        check({15'h0, linkCtl.lfpsExit}, 16'h0000);
        settle(40);
        check({15'h0, linkCtl.lfpsExit}, 16'h0001);
        lfpsPresent = 1'b0;
        inLowPower = 1'b0;
    endtask : test_debounce

    // A second reset mid-run must restore the link defaults
    task automatic test_reset_again();
        regWrite(LINK_MISC_CONTROL_OFS, 8'hBB);
        @(negedge clk);
        reset_n = 1'b0;
        settle(2);
        reset_n = 1'b1;
        expectRead(LINK_MISC_CONTROL_OFS, 8'h44);
    endtask : test_reset_again

    initial begin
        settle(10);
        reset_n = 1'b1;
        test_reset_values();
        test_strap_follow();
        test_override();
        test_adaptive();
        test_lfps_equalization_apply();
        test_link_bits();
        test_debounce();
        test_reset_again();
        tally_and_finish();
    end

endmodule : uel_rx_eq_link_regs_tb
